//--- hdl/hps_pkg.sv
// constants and types shared by the playback sequencer files
package hps_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE      = 8'h01;
  localparam logic [7:0] ADDR_DRIVE_VALUE = 8'h02;
  localparam logic [7:0] ADDR_FLOAT     = 8'h03;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0B;
  localparam logic [7:0] ADDR_TRIGGER   = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL   = 8'h1D;

  // ------------------------------------------------------------------
  // field positions and codes
  // ------------------------------------------------------------------
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_MSB      = 2;
  localparam int unsigned STANDBY_BIT   = 6;
  localparam int unsigned FLOAT_BIT     = 4;
  localparam int unsigned TRIGGER_BIT   = 0;
  localparam int unsigned SIGN_SEL_BIT  = 3;
  localparam int unsigned WAIT_FLAG_BIT = 7;
  localparam logic [2:0]  MODE_INTERNAL = 3'h0;
  localparam logic [2:0]  MODE_REALTIME = 3'h5;
  localparam logic [6:0]  SLOT_END      = 7'h00;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_MODE      = 8'h40;
  localparam logic [7:0] RST_DRIVE_VALUE = 8'h00;
  localparam logic [7:0] RST_FLOAT     = 8'h00;
  localparam logic [7:0] RST_SLOT      = 8'h00;
  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [7:0] RST_RDATA     = 8'h00;

  // ------------------------------------------------------------------
  // counts and timing
  // ------------------------------------------------------------------
  localparam int unsigned SLOT_COUNT    = 8;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned WAIT_UNIT_MS  = 10;
  localparam int unsigned WAIT_UNIT_CYCLES = WAIT_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    HPS_IDLE,
    HPS_FETCH,
    HPS_PLAY,
    HPS_WAIT
  } hps_state_type;

endpackage : hps_pkg

//--- hdl/hps_wait_if.sv
// carrier between sequencer and its wait timer
`timescale 1ns/100ps
interface hps_wait_if;
  logic       start;
  logic       abort;
  logic [6:0] units;
  logic       done;

  modport ctrl  (output start, output abort, output units, input done);
  modport timer (input start, input abort, input units, output done);
endinterface : hps_wait_if

//--- hdl/hps_wait_timer.sv
// wait timer counting whole wait units
`timescale 1ns/100ps
module hps_wait_timer #(
  parameter int unsigned UNIT_CYCLES = hps_pkg::WAIT_UNIT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  hps_wait_if.timer wt
);

  localparam int unsigned TW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(UNIT_CYCLES - 1);

  logic          busy_reg;
  logic          done_reg;
  logic [TW-1:0] tick_reg;
  logic [6:0]    units_reg;

  wire tick_wrap = busy_reg && (tick_reg == TICK_LAST);
  wire last_unit = (units_reg == 7'h01);

  assign wt.done = done_reg;

  // ------------------------------------------------------------------
  // counters
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      tick_reg  <= '0;
      units_reg <= 7'h00;
    end
    else if (wt.abort)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (wt.start)
    begin
      busy_reg  <= 1'b1;
      done_reg  <= 1'b0;
      tick_reg  <= '0;
      units_reg <= wt.units;
    end
    else
    begin
      done_reg <= tick_wrap && last_unit;
      tick_reg <= tick_wrap ? '0 : tick_reg + TW'(busy_reg);
      if (tick_wrap)
      begin
        units_reg <= units_reg - 7'h01;
        busy_reg  <= !last_unit;
      end
    end
  end

endmodule : hps_wait_timer

//--- hdl/hps_sequencer.sv
// playback control registers, sequencer and real-time drive path
`timescale 1ns/100ps
module hps_sequencer #(
  parameter int unsigned WAIT_CYCLES = hps_pkg::WAIT_UNIT_CYCLES,
  parameter int unsigned SLOTS       = hps_pkg::SLOT_COUNT
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              enable_pin_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              wave_done_i,
  output logic                   wave_start_o,
  output logic                   wave_abort_o,
  output logic      [6:0]        wave_index_o,
  output logic signed [8:0]      drive_level_o,
  output logic                   drive_active_o,
  output logic                   out_float_o,
  output logic                   seq_busy_o
);

  localparam int unsigned SW = $clog2(SLOTS);
  localparam logic [SW-1:0] SLOT_LAST_IDX = SW'(SLOTS - 1);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic signed [8:0] to_level(
    input logic [7:0] value,
    input logic       unsigned_fmt
  );
    to_level = unsigned_fmt ? $signed({1'b0, value})
                            : $signed({value[7], value});
  endfunction : to_level

  function automatic logic slot_is_end(input logic [7:0] slot);
    slot_is_end = (slot[6:0] == hps_pkg::SLOT_END);
  endfunction : slot_is_end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [7:0]             mode_reg;
  logic [7:0]             drive_value_reg;
  logic [7:0]             float_reg;
  logic [7:0]             control_reg;
  logic [7:0]             slot_reg [SLOTS];
  logic                   trigger_reg;
  logic                   trigger_next;
  logic [1:0]             en_sync_reg;
  hps_pkg::hps_state_type state_reg;
  hps_pkg::hps_state_type state_next;
  logic [SW-1:0]          slot_idx_reg;
  logic [SW-1:0]          slot_idx_next;
  logic                   wave_start_next;
  logic                   wave_abort_next;
  logic [6:0]             wave_index_next;
  logic                   seq_clear;
  logic                   wait_start;
  logic                   wait_abort;
  logic [7:0]             rd_mux;

  hps_wait_if wait_bus ();

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire wr_mode    = reg_wr_i && (reg_addr_i == hps_pkg::ADDR_MODE);
  wire wr_drive   = reg_wr_i && (reg_addr_i == hps_pkg::ADDR_DRIVE_VALUE);
  wire wr_float   = reg_wr_i && (reg_addr_i == hps_pkg::ADDR_FLOAT);
  wire wr_trigger = reg_wr_i && (reg_addr_i == hps_pkg::ADDR_TRIGGER);
  wire wr_control = reg_wr_i && (reg_addr_i == hps_pkg::ADDR_CONTROL);
  wire slot_hit   = (reg_addr_i >= hps_pkg::ADDR_SLOT_FIRST) &&
                    (reg_addr_i <= hps_pkg::ADDR_SLOT_LAST);
  wire [7:0] slot_off = reg_addr_i - hps_pkg::ADDR_SLOT_FIRST;
  wire [SW-1:0] wr_slot_idx = slot_off[SW-1:0];
  wire wr_slot    = reg_wr_i && slot_hit;

  wire [2:0] mode = mode_reg[hps_pkg::MODE_MSB:hps_pkg::MODE_LSB];
  wire standby    = mode_reg[hps_pkg::STANDBY_BIT];
  wire enable_pin = en_sync_reg[1];
  wire enabled    = enable_pin && !standby;
  wire rt_mode    = enabled && (mode == hps_pkg::MODE_REALTIME);
  wire unsigned_fmt = control_reg[hps_pkg::SIGN_SEL_BIT];
  wire [7:0] cur_slot = slot_reg[slot_idx_reg];
  wire cancel     = !trigger_reg || !enabled;
  wire last_slot  = (slot_idx_reg == SLOT_LAST_IDX);

  // float request gates straight through, no pipeline
  assign out_float_o = enabled && float_reg[hps_pkg::FLOAT_BIT];

  assign wait_bus.start = wait_start;
  assign wait_bus.abort = wait_abort;
  assign wait_bus.units = cur_slot[6:0];
  assign seq_busy_o     = (state_reg != hps_pkg::HPS_IDLE);

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb
  begin
    if (reg_addr_i == hps_pkg::ADDR_MODE)
      rd_mux = mode_reg;
    else if (reg_addr_i == hps_pkg::ADDR_DRIVE_VALUE)
      rd_mux = drive_value_reg;
    else if (reg_addr_i == hps_pkg::ADDR_FLOAT)
      rd_mux = float_reg;
    else if (slot_hit)
      rd_mux = slot_reg[wr_slot_idx];
    else if (reg_addr_i == hps_pkg::ADDR_TRIGGER)
      rd_mux = {7'h00, trigger_reg};
    else if (reg_addr_i == hps_pkg::ADDR_CONTROL)
      rd_mux = control_reg;
    else
      rd_mux = 8'h00;
  end

  // ------------------------------------------------------------------
  // trigger bit
  // ------------------------------------------------------------------
  always_comb
  begin
    if (wr_trigger)
      trigger_next = reg_wdata_i[hps_pkg::TRIGGER_BIT];
    else if (seq_clear)
      trigger_next = 1'b0;
    else
      trigger_next = trigger_reg;
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next      = state_reg;
    slot_idx_next   = slot_idx_reg;
    wave_start_next = 1'b0;
    wave_abort_next = 1'b0;
    wave_index_next = wave_index_o;
    seq_clear       = 1'b0;
    wait_start      = 1'b0;
    wait_abort      = 1'b0;
    case (state_reg)
      hps_pkg::HPS_IDLE:
      begin
        if (trigger_reg && enabled)
        begin
          if (mode == hps_pkg::MODE_INTERNAL)
          begin
            slot_idx_next = '0;
            state_next    = hps_pkg::HPS_FETCH;
          end
          else
            seq_clear = 1'b1;
        end
        else if (trigger_reg)
          seq_clear = 1'b1;
      end
      hps_pkg::HPS_FETCH:
      begin
        if (cancel)
        begin
          seq_clear  = !enabled;
          state_next = hps_pkg::HPS_IDLE;
        end
        else if (slot_is_end(cur_slot))
        begin
          seq_clear  = 1'b1;
          state_next = hps_pkg::HPS_IDLE;
        end
        else if (cur_slot[hps_pkg::WAIT_FLAG_BIT])
        begin
          wait_start = 1'b1;
          state_next = hps_pkg::HPS_WAIT;
        end
        else
        begin
          wave_start_next = 1'b1;
          wave_index_next = cur_slot[6:0];
          state_next      = hps_pkg::HPS_PLAY;
        end
      end
      hps_pkg::HPS_PLAY:
      begin
        if (cancel)
        begin
          wave_abort_next = 1'b1;
          seq_clear       = !enabled;
          state_next      = hps_pkg::HPS_IDLE;
        end
        else if (wave_done_i)
        begin
          if (last_slot)
          begin
            seq_clear  = 1'b1;
            state_next = hps_pkg::HPS_IDLE;
          end
          else
          begin
            slot_idx_next = slot_idx_reg + SW'(1);
            state_next    = hps_pkg::HPS_FETCH;
          end
        end
      end
      hps_pkg::HPS_WAIT:
      begin
        if (cancel)
        begin
          wait_abort = 1'b1;
          seq_clear  = !enabled;
          state_next = hps_pkg::HPS_IDLE;
        end
        else if (wait_bus.done)
        begin
          if (last_slot)
          begin
            seq_clear  = 1'b1;
            state_next = hps_pkg::HPS_IDLE;
          end
          else
          begin
            slot_idx_next = slot_idx_reg + SW'(1);
            state_next    = hps_pkg::HPS_FETCH;
          end
        end
      end
      default:
        state_next = hps_pkg::HPS_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_reg      <= hps_pkg::RST_MODE;
      drive_value_reg <= hps_pkg::RST_DRIVE_VALUE;
      float_reg     <= hps_pkg::RST_FLOAT;
      control_reg   <= hps_pkg::RST_CONTROL;
      trigger_reg   <= 1'b0;
      reg_rdata_o   <= hps_pkg::RST_RDATA;
      en_sync_reg   <= 2'h0;
    end
    else
    begin
      en_sync_reg <= {en_sync_reg[0], enable_pin_i};
      trigger_reg <= trigger_next;
      if (wr_mode)
        mode_reg <= reg_wdata_i;
      if (wr_drive)
        drive_value_reg <= reg_wdata_i;
      if (wr_float)
        float_reg <= reg_wdata_i & 8'h10;
      if (wr_control)
        control_reg <= reg_wdata_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < SLOTS; i++)
        slot_reg[i] <= hps_pkg::RST_SLOT;
    end
    else if (wr_slot)
      slot_reg[wr_slot_idx] <= reg_wdata_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg    <= hps_pkg::HPS_IDLE;
      slot_idx_reg <= '0;
      wave_start_o <= 1'b0;
      wave_abort_o <= 1'b0;
      wave_index_o <= 7'h00;
    end
    else
    begin
      state_reg    <= state_next;
      slot_idx_reg <= slot_idx_next;
      wave_start_o <= wave_start_next;
      wave_abort_o <= wave_abort_next;
      wave_index_o <= wave_index_next;
    end
  end

  // ------------------------------------------------------------------
  // real-time drive path
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      drive_level_o  <= 9'sh000;
      drive_active_o <= 1'b0;
    end
    else
    begin
      drive_active_o <= rt_mode;
      drive_level_o  <= rt_mode ? to_level(drive_value_reg, unsigned_fmt)
                                : 9'sh000;
    end
  end

  // ------------------------------------------------------------------
  // wait timer
  // ------------------------------------------------------------------
  hps_wait_timer #(
    .UNIT_CYCLES (WAIT_CYCLES)
  ) u_wait_timer (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wt       (wait_bus.timer)
  );

endmodule : hps_sequencer

//--- tb/hps_engine_model.sv
// playback engine stand-in answering waveform starts
`timescale 1ns/100ps
module hps_engine_model (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [6:0] index_i,
  input  wire logic [7:0] lat_i,
  output logic            done_o
);
  logic [7:0] cnt_reg;
  logic       run_reg;
  logic [6:0] seen [$];

  always @(posedge clk_i or negedge arst_n_i)
  begin
    done_o <= 1'b0;
    if (!arst_n_i)
      run_reg <= 1'b0;
    else if (abort_i)
      run_reg <= 1'b0;
    else if (start_i)
    begin
      seen.push_back(index_i);
      run_reg <= 1'b1;
      cnt_reg <= lat_i;
    end
    else if (run_reg && cnt_reg == 8'h00)
    begin
      run_reg <= 1'b0;
      done_o  <= 1'b1;
    end
    else if (run_reg)
      cnt_reg <= cnt_reg - 8'h01;
  end
endmodule : hps_engine_model

//--- tb/hps_sequencer_assertions.sv
// port checks for the playback sequencer
`timescale 1ns/100ps
module hps_sequencer_assertions #(
  parameter int unsigned WAIT_CYCLES = 20,
  parameter int unsigned SLOTS       = 8
) (
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  input wire logic              enable_pin_i,
  input wire logic              reg_wr_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              wave_start_o,
  input wire logic              wave_abort_o,
  input wire logic [6:0]        wave_index_o,
  input wire logic signed [8:0] drive_level_o,
  input wire logic              drive_active_o,
  input wire logic              out_float_o,
  input wire logic              seq_busy_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  wire logic drv_wr;
  wire logic flt_wr;
  assign drv_wr = reg_wr_i && reg_addr_i == hps_pkg::ADDR_DRIVE_VALUE;
  assign flt_wr = reg_wr_i && reg_addr_i == hps_pkg::ADDR_FLOAT;

  drive_zero_a: assert property (
    !drive_active_o [*2] |-> drive_level_o == 9'h000)
    else $error("drive level outside real-time mode");
  drive_follow_a: assert property (
    drv_wr && !reg_wdata_i[7] && drive_active_o ##2 drive_active_o
    |-> drive_level_o == {1'b0, $past(reg_wdata_i, 2)})
    else $error("drive level missed new value");
  sign_ext_a: assert property (
    drive_level_o[8] |-> drive_level_o[7])
    else $error("drive level sign bits disagree");
  float_pin_a: assert property (
    !enable_pin_i [*4] |-> !out_float_o)
    else $error("float while disabled");
  float_off_a: assert property (
    flt_wr && !reg_wdata_i[4] |=> !out_float_o)
    else $error("float not released");
  start_busy_a: assert property (
    wave_start_o |-> seq_busy_o)
    else $error("start while idle");
  start_gap_a: assert property (
    wave_start_o |=> !wave_start_o [*2])
    else $error("starts too close");
  index_hold_a: assert property (
    !wave_start_o |-> $stable(wave_index_o))
    else $error("index moved without start");
  abort_idle_a: assert property (
    wave_abort_o |-> ##[1:3] !seq_busy_o)
    else $error("abort left sequencer busy");
endmodule : hps_sequencer_assertions

bind hps_sequencer hps_sequencer_assertions #(
  .WAIT_CYCLES(WAIT_CYCLES), .SLOTS(SLOTS)) chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .enable_pin_i(enable_pin_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .wave_start_o(wave_start_o),
  .wave_abort_o(wave_abort_o), .wave_index_o(wave_index_o),
  .drive_level_o(drive_level_o), .drive_active_o(drive_active_o),
  .out_float_o(out_float_o), .seq_busy_o(seq_busy_o));

//--- tb/test_hps_sequencer.sv
// self-checking bench for the playback sequencer
`timescale 1ns/100ps
module test_hps_sequencer;
  localparam int W   = 20;
  localparam int DLY = 5;
  logic              clk_i;
  logic              arst_n_i;
  logic              enable_pin_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [7:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic [7:0]        reg_rdata_o;
  logic              wave_done_i;
  logic              wave_start_o;
  logic              wave_abort_o;
  logic [6:0]        wave_index_o;
  logic signed [8:0] drive_level_o;
  logic              drive_active_o;
  logic              out_float_o;
  logic              seq_busy_o;
  logic [7:0]        lat;
  logic [7:0]        v;
  logic              ab;
  int                err_count;
  int                checks;
  int                t;
  // write flag, address, data, expected read
  localparam logic [24:0] ROWS [12] = '{
    {1'b0, 8'h01, 8'h00, 8'h40}, {1'b0, 8'h02, 8'h00, 8'h00},
    {1'b0, 8'h03, 8'h00, 8'h00}, {1'b0, 8'h04, 8'h00, 8'h00},
    {1'b0, 8'h0B, 8'h00, 8'h00}, {1'b1, 8'h02, 8'hA5, 8'hA5},
    {1'b1, 8'h03, 8'hFF, 8'h10}, {1'b1, 8'h04, 8'h81, 8'h81},
    {1'b1, 8'h0B, 8'h7F, 8'h7F}, {1'b1, 8'h10, 8'h55, 8'h00},
    {1'b1, 8'h1D, 8'h08, 8'h08}, {1'b1, 8'h01, 8'h05, 8'h05}};

  hps_sequencer #(.WAIT_CYCLES(W), .SLOTS(8)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .enable_pin_i(enable_pin_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .wave_done_i(wave_done_i), .wave_start_o(wave_start_o),
    .wave_abort_o(wave_abort_o), .wave_index_o(wave_index_o),
    .drive_level_o(drive_level_o), .drive_active_o(drive_active_o),
    .out_float_o(out_float_o), .seq_busy_o(seq_busy_o));
  hps_engine_model eng (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(wave_start_o),
    .abort_i(wave_abort_o), .index_i(wave_index_o), .lat_i(lat),
    .done_o(wave_done_i));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task chk(input logic [8:0] s, input logic [8:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #DLY;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] q);
    tick(1);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'b0;
    q = reg_rdata_o;
  endtask : rd
  task fl(input logic [7:0] a, input logic [7:0] d, input logic e);
    wr(a, d);
    chk(out_float_o, e);
  endtask : fl
  task play(input logic [63:0] s, output int n);
    int         j;
    logic [7:0] b;
    j = 0;
    n = 0;
    for (int i = 0; i < 8; i++)
      wr(hps_pkg::ADDR_SLOT_FIRST + 8'(i), s[8*i +: 8]);
    eng.seen.delete();
    wr(hps_pkg::ADDR_TRIGGER, 8'h01);
    tick(2);
    while (seq_busy_o === 1'b1 && n < 4000)
    begin
      tick(1);
      n++;
    end
    for (int i = 0; i < 8; i++)
    begin
      b = s[8*i +: 8];
      if (b[6:0] == 7'h00)
        break;
      if (!b[7])
      begin
        chk(eng.seen[j], b[6:0]);
        j++;
      end
    end
    chk(9'(eng.seen.size()), 9'(j));
    rd(hps_pkg::ADDR_TRIGGER, v);
    chk(v, 8'h00);
    $display("end sequence %h", s);
  endtask : play
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  initial
  begin
    arst_n_i     = 1'b0;
    enable_pin_i = 1'b1;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    reg_addr_i   = 8'h00;
    reg_wdata_i  = 8'h00;
    lat          = 8'h03;
    err_count    = 0;
    checks       = 0;
    repeat (4) @(posedge clk_i);
    #DLY;
    arst_n_i = 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i][24])
        wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], v);
      chk(v, ROWS[i][7:0]);
    end
    $display("end register table");
    tick(2);
    chk(drive_active_o, 1'b1);
    chk(drive_level_o, 9'h0A5);
    wr(hps_pkg::ADDR_CONTROL, 8'h00);
    tick(2);
    chk(drive_level_o, 9'h1A5);
    wr(hps_pkg::ADDR_DRIVE_VALUE, 8'h5A);
    tick(2);
    chk(drive_level_o, 9'h05A);
    wr(hps_pkg::ADDR_MODE, 8'h00);
    tick(2);
    chk(drive_level_o, 9'h000);
    chk(drive_active_o, 1'b0);
    $display("end real-time");
    chk(out_float_o, 1'b1);
    fl(hps_pkg::ADDR_MODE, 8'h40, 1'b0);
    fl(hps_pkg::ADDR_MODE, 8'h00, 1'b1);
    enable_pin_i = 1'b0;
    tick(4);
    chk(out_float_o, 1'b0);
    enable_pin_i = 1'b1;
    tick(3);
    chk(out_float_o, 1'b1);
    fl(hps_pkg::ADDR_FLOAT, 8'h00, 1'b0);
    $display("end float");
    play(64'h0000_0000_0007_8503, t);
    lat = 8'h00;
    play(64'h0807_0605_0403_0201, t);
    play(64'h0000_0000_0000_0085, t);
    chk(9'(t >= 5 * W && t <= 5 * W + 8), 9'h001);
    play(64'h0000_0000_0000_0000, t);
    lat = 8'h3C;
    wr(hps_pkg::ADDR_SLOT_FIRST, 8'h09);
    wr(hps_pkg::ADDR_TRIGGER, 8'h01);
    tick(4);
    rd(hps_pkg::ADDR_TRIGGER, v);
    chk(v, 8'h01);
    fl(hps_pkg::ADDR_FLOAT, 8'h10, 1'b1);
    chk(seq_busy_o, 1'b1);
    wr(hps_pkg::ADDR_TRIGGER, 8'h00);
    ab = 1'b0;
    repeat (4)
    begin
      if (wave_abort_o === 1'b1)
        ab = 1'b1;
      tick(1);
    end
    chk(ab, 1'b1);
    chk(seq_busy_o, 1'b0);
    wr(hps_pkg::ADDR_MODE, 8'h05);
    wr(hps_pkg::ADDR_TRIGGER, 8'h01);
    tick(2);
    rd(hps_pkg::ADDR_TRIGGER, v);
    chk(v, 8'h00);
    chk(seq_busy_o, 1'b0);
    $display("end cancel");
    arst_n_i = 1'b0;
    #DLY;
    chk(out_float_o, 1'b0);
    tick(1);
    arst_n_i = 1'b1;
    rd(hps_pkg::ADDR_FLOAT, v);
    chk(v, 8'h00);
    $display("end reset");
    test_done();
  end
endmodule : test_hps_sequencer
